// file: fbb_pkg.sv
package fbb_pkg;
	// ---------------------------------------------------------------
	// Geometry and defaults
	// ---------------------------------------------------------------
	localparam int BLK_W         = 4;
	localparam int PG_W          = 6;
	localparam int LEN_W         = 12;
	localparam int PAGE_BYTES_DEF = 2048;
	localparam int SPI_DIV_DEF   = 4;
	localparam int MAX_RETRY_DEF = 4;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int CLK_MHZ    = 200;
	localparam int CS_HIGH_NS = 100;
	localparam int CS_GAP_CYC = (CS_HIGH_NS * CLK_MHZ + 999) / 1000;

	// ---------------------------------------------------------------
	// Command and feature bytes
	// ---------------------------------------------------------------
	localparam logic [7:0] CMD_READ_ARRAY = 8'h13;
	localparam logic [7:0] CMD_READ_BUF   = 8'h03;
	localparam logic [7:0] CMD_LOAD       = 8'h02;
	localparam logic [7:0] CMD_EXEC       = 8'h10;
	localparam logic [7:0] CMD_ERASE      = 8'hD8;
	localparam logic [7:0] CMD_WREN       = 8'h06;
	localparam logic [7:0] CMD_GET_FEAT   = 8'h0F;
	localparam logic [7:0] CMD_RESET      = 8'hFF;
	localparam logic [7:0] CMD_PROT_EXEC  = 8'h2A;
	localparam logic [7:0] FEAT_STATUS    = 8'hC0;
	localparam logic [7:0] BAD_MARK       = 8'h00;
	localparam logic [7:0] PAD_BYTE       = 8'hFF;
	localparam logic [7:0] DUMMY_BYTE     = 8'h00;

	// ---------------------------------------------------------------
	// Status byte fields
	// ---------------------------------------------------------------
	localparam int         ST_BUSY_BIT  = 0;
	localparam int         ST_EFAIL_BIT = 2;
	localparam int         ST_PFAIL_BIT = 3;
	localparam int         ST_ECC_LSB   = 4;
	localparam logic [1:0] ECC_UNCORR   = 2'h2;
	localparam logic [1:0] ECC_NEAR     = 2'h3;

	// ---------------------------------------------------------------
	// Frame lengths and byte indices
	// ---------------------------------------------------------------
	localparam logic [15:0] LEN_CMD      = 16'h0001;
	localparam logic [15:0] LEN_ROW      = 16'h0004;
	localparam logic [15:0] LEN_POLL     = 16'h0003;
	localparam logic [15:0] POLL_STAT_IX = 16'h0002;
	localparam logic [15:0] RDBUF_HDR    = 16'h0004;
	localparam logic [15:0] LOAD_HDR     = 16'h0003;

	// ---------------------------------------------------------------
	// Types
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		OP_READ  = 3'h0,
		OP_PROG  = 3'h1,
		OP_ERASE = 3'h2,
		OP_PROT  = 3'h3,
		OP_INIT  = 3'h4,
		OP_SCAN  = 3'h5
	} fbb_op_e;

	typedef enum logic [2:0] {
		RS_OK         = 3'h0,
		RS_REFUSED    = 3'h1,
		RS_ERASE_FAIL = 3'h2,
		RS_PROG_FAIL  = 3'h3,
		RS_PROT_FAIL  = 3'h4,
		RS_RELOCATED  = 3'h5,
		RS_ECC_UNCORR = 3'h6
	} fbb_rs_e;

	typedef struct packed {
		fbb_op_e            op;
		logic [BLK_W-1:0]   blk;
		logic [PG_W-1:0]    page;
		logic [LEN_W-1:0]   len;
	} fbb_req_s;

	typedef struct packed {
		fbb_rs_e            status;
		logic [BLK_W-1:0]   blk;
		logic [1:0]         ecc;
		logic               rewrite;
	} fbb_resp_s;

	typedef struct packed {
		logic sck;
		logic cs_n;
		logic mosi;
	} fbb_spi_s;
endpackage : fbb_pkg

// file: fbb_bbt_mem.sv
`timescale 1ns/10ps
module fbb_bbt_mem #(
	parameter int AW = 11,
	parameter int W  = 1
) (
	input  wire logic          clk_in,
	input  wire logic          we_in,
	input  wire logic [AW-1:0] waddr_in,
	input  wire logic [W-1:0]  wdata_in,
	input  wire logic [AW-1:0] raddr_in,
	output logic      [W-1:0]  rdata_out
);
	import fbb_pkg::*;

	logic [W-1:0] mem [0:(1<<AW)-1];

	always_ff @(posedge clk_in) begin
		if (we_in)
			mem[waddr_in] <= wdata_in;
		rdata_out <= mem[raddr_in];
	end
endmodule : fbb_bbt_mem

// file: fbb_spi.sv
`timescale 1ns/10ps
module fbb_spi #(
	parameter int DIV = 4
) (
	input  wire logic       clk_in,
	input  wire logic       nrst_in,
	input  wire logic       go_in,
	input  wire logic [7:0] tx_in,
	input  wire logic       miso_in,
	output logic            sck_out,
	output logic            mosi_out,
	output logic            busy_out,
	output logic            done_out,
	output logic [7:0]      rx_out
);
	import fbb_pkg::*;

	localparam int             DW       = (DIV > 1) ? $clog2(DIV) : 1;
	localparam logic [DW-1:0]  DIV_LAST = DW'(DIV - 1);

	logic [1:0]    miso_sync;
	logic [7:0]    sh_tx;
	logic [7:0]    sh_rx;
	logic [2:0]    bitn;
	logic [DW-1:0] div;
	wire           tick = busy_out && (div == DIV_LAST);

	// ---------------------------------------------------------------
	// Mode 0 byte shifter, sample on rise, shift on fall
	// ---------------------------------------------------------------
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			miso_sync <= 2'h0;
			sh_tx     <= 8'h00;
			sh_rx     <= 8'h00;
			bitn      <= 3'h0;
			div       <= '0;
			sck_out   <= 1'b0;
			mosi_out  <= 1'b0;
			busy_out  <= 1'b0;
			done_out  <= 1'b0;
			rx_out    <= 8'h00;
		end else begin
			miso_sync <= {miso_sync[0], miso_in};
			done_out  <= 1'b0;
			if (go_in && !busy_out) begin
				busy_out <= 1'b1;
				sh_tx    <= tx_in;
				mosi_out <= tx_in[7];
				bitn     <= 3'h0;
				div      <= '0;
			end else if (busy_out) begin
				div <= tick ? '0 : div + 1'b1;
				if (tick && !sck_out) begin
					sck_out <= 1'b1;
					sh_rx   <= {sh_rx[6:0], miso_sync[1]};
				end else if (tick) begin
					sck_out <= 1'b0;
					if (bitn == 3'h7) begin
						busy_out <= 1'b0;
						done_out <= 1'b1;
						rx_out   <= sh_rx;
					end else begin
						bitn     <= bitn + 1'b1;
						sh_tx    <= {sh_tx[6:0], 1'b0};
						mosi_out <= sh_tx[6];
					end
				end
			end
		end
	end
endmodule : fbb_spi

// file: fbb_ctrl.sv
// Behaviour
// - Program, protect and erase are never sent to a block known to be bad.
// - The install scan reads column 0 of page 0 per block; 00 marks it bad.
// - Blocks found bad by the scan never receive an erase.
// - A failed erase puts the block in the bad-block table.
// - A failed program is rewritten into another block from the user buffer.
// - After protect, the status byte is fetched and a program-fail means protect failure.
// - After a read, ECC status is fetched and a rewrite is advised near the limit.
// - Read data always goes with an ECC verdict; uncorrectable data is flagged.
// - Blocks are retired only on program, protect or erase status failure, not on ECC errors.
// - Unused page bytes of a program are padded with ones, never zeros.
// - Replacement blocks come from a rotating pointer so cycling spreads out.
// - While busy, only the get-feature poll is sent.
`timescale 1ns/10ps
module fbb_ctrl #(
	parameter int PAGE_BYTES = fbb_pkg::PAGE_BYTES_DEF,
	parameter int SPI_DIV    = fbb_pkg::SPI_DIV_DEF,
	parameter int MAX_RETRY  = fbb_pkg::MAX_RETRY_DEF
) (
	input  wire logic                CLK_IN,
	input  wire logic                NRST_IN,
	input  wire logic                REQ_VALID_IN,
	input  wire fbb_pkg::fbb_req_s   REQ_IN,
	output logic                     REQ_READY_OUT,
	input  wire logic [7:0]          DATA_IN,
	output logic                     DATA_TAKE_OUT,
	output logic                     DATA_RESTART_OUT,
	output logic [7:0]               RD_DATA_OUT,
	output logic                     RD_VALID_OUT,
	output logic                     RESP_VALID_OUT,
	output fbb_pkg::fbb_resp_s       RESP_OUT,
	output fbb_pkg::fbb_spi_s        SPI_OUT,
	input  wire logic                MISO_IN
);
	import fbb_pkg::*;

	// ---------------------------------------------------------------
	// Types and sizes
	// ---------------------------------------------------------------
	typedef enum logic [13:0] {
		S_IDLE  = 14'h0001,
		S_GAP   = 14'h0002,
		S_CHECK = 14'h0004,
		S_DONE  = 14'h0008,
		S_RESP  = 14'h0010,
		S_RST   = 14'h0020,
		S_WREN  = 14'h0040,
		S_RD13  = 14'h0080,
		S_RDBUF = 14'h0100,
		S_LOAD  = 14'h0200,
		S_EXEC  = 14'h0400,
		S_ERASE = 14'h0800,
		S_PROT  = 14'h1000,
		S_POLL  = 14'h2000
	} fbb_state_e;

	localparam int             RW        = $clog2(MAX_RETRY + 1);
	localparam logic [RW-1:0]  RETRY_MAX = RW'(MAX_RETRY);
	localparam int             GW        = $clog2(CS_GAP_CYC + 1);
	localparam logic [GW-1:0]  GAP_LAST  = GW'(CS_GAP_CYC - 1);
	localparam logic [15:0]    LOAD_LEN  = LOAD_HDR + 16'(PAGE_BYTES);

	function automatic logic is_frame(input fbb_state_e st);
		is_frame = !(st inside {S_IDLE, S_GAP, S_CHECK, S_DONE, S_RESP});
	endfunction : is_frame

	function automatic logic [7:0] hdr_byte(input logic [7:0]  cmd,
	                                        input logic [1:0]  i,
	                                        input logic [23:0] r);
		case (i)
			2'h0:    hdr_byte = cmd;
			2'h1:    hdr_byte = r[23:16];
			2'h2:    hdr_byte = r[15:8];
			default: hdr_byte = r[7:0];
		endcase
	endfunction : hdr_byte

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	fbb_state_e       state;
	fbb_state_e       pend;
	fbb_state_e       follow;
	fbb_op_e          op;
	logic [BLK_W-1:0] blk;
	logic [BLK_W-1:0] alloc;
	logic [PG_W-1:0]  page;
	logic [LEN_W-1:0] len;
	logic [15:0]      idx;
	logic [15:0]      flen;
	logic             launched;
	logic [GW-1:0]    gap;
	logic             chk;
	logic [RW-1:0]    retry;
	logic [7:0]       stat;
	logic             go;
	logic [7:0]       tx;
	logic [7:0]       tx_byte;
	logic             cs_n;
	logic             bbt_we;
	logic [BLK_W-1:0] bbt_wa;
	logic             bbt_wd;
	logic             bbt_bad;
	logic             spi_sck;
	logic             spi_mosi;
	logic             spi_busy;
	logic             spi_done;
	logic [7:0]       spi_rx;

	// ---------------------------------------------------------------
	// Decoding
	// ---------------------------------------------------------------
	wire [23:0] row       = 24'({blk, page});
	wire        last      = (idx == flen - 16'h0001);
	wire        load_data = (idx >= LOAD_HDR) && ((idx - LOAD_HDR) < 16'(len));
	wire        in_frame  = is_frame(state);
	wire [1:0]  ecc       = stat[ST_ECC_LSB +: 2];
	wire        st_efail  = stat[ST_EFAIL_BIT];
	wire        st_pfail  = stat[ST_PFAIL_BIT];
	wire        rx_busy   = spi_rx[ST_BUSY_BIT];
	wire        last_blk  = (blk == {BLK_W{1'b1}});
	wire        relocating = (retry != '0);
	wire        done_fail = (op == OP_ERASE) ? st_efail : (op != OP_READ) && st_pfail;

	assign SPI_OUT = {spi_sck, cs_n, spi_mosi};

	always_comb begin
		case (state)
			S_RST, S_WREN:                   flen = LEN_CMD;
			S_RD13, S_EXEC, S_ERASE, S_PROT: flen = LEN_ROW;
			S_POLL:                          flen = LEN_POLL;
			S_RDBUF:                         flen = RDBUF_HDR + 16'(len);
			S_LOAD:                          flen = LOAD_LEN;
			default:                         flen = LEN_CMD;
		endcase
	end

	always_comb begin
		case (state)
			S_RST:   tx_byte = CMD_RESET;
			S_WREN:  tx_byte = CMD_WREN;
			S_RD13:  tx_byte = hdr_byte(CMD_READ_ARRAY, idx[1:0], row);
			S_EXEC:  tx_byte = hdr_byte(CMD_EXEC, idx[1:0], row);
			S_ERASE: tx_byte = hdr_byte(CMD_ERASE, idx[1:0], row);
			S_PROT:  tx_byte = hdr_byte(CMD_PROT_EXEC, idx[1:0], row);
			S_POLL:  tx_byte = (idx == 16'h0000) ? CMD_GET_FEAT :
			                   (idx == 16'h0001) ? FEAT_STATUS : DUMMY_BYTE;
			S_RDBUF: tx_byte = (idx == 16'h0000) ? CMD_READ_BUF : DUMMY_BYTE;
			S_LOAD:  tx_byte = (idx == 16'h0000) ? CMD_LOAD :
			                   (idx < LOAD_HDR) ? DUMMY_BYTE :
			                   load_data ? DATA_IN : PAD_BYTE;
			default: tx_byte = DUMMY_BYTE;
		endcase
	end

	// Next frame once the current one ends
	always_comb begin
		follow = S_IDLE;
		case (state)
			S_RST, S_RD13, S_EXEC, S_ERASE, S_PROT: follow = S_POLL;
			S_LOAD: follow = S_EXEC;
			S_WREN: begin
				if (op == OP_PROG)
					follow = S_LOAD;
				else if (op == OP_ERASE)
					follow = S_ERASE;
				else
					follow = S_PROT;
			end
			S_POLL: begin
				if (rx_busy)
					follow = S_POLL;
				else if (op == OP_INIT)
					follow = S_RD13;
				else if (op == OP_SCAN || op == OP_READ)
					follow = S_RDBUF;
				else
					follow = S_DONE;
			end
			S_RDBUF: begin
				if (op != OP_SCAN)
					follow = S_DONE;
				else if (!last_blk)
					follow = S_RD13;
			end
			default: follow = S_IDLE;
		endcase
	end

	// ---------------------------------------------------------------
	// Sequencer
	// ---------------------------------------------------------------
	always_ff @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			state            <= S_GAP;
			pend             <= S_RST;
			op               <= OP_INIT;
			blk              <= '0;
			alloc            <= '0;
			page             <= '0;
			len              <= '0;
			idx              <= 16'h0000;
			launched         <= 1'b0;
			gap              <= '0;
			chk              <= 1'b0;
			retry            <= '0;
			stat             <= 8'h00;
			go               <= 1'b0;
			tx               <= 8'h00;
			cs_n             <= 1'b1;
			bbt_we           <= 1'b0;
			bbt_wa           <= '0;
			bbt_wd           <= 1'b0;
			REQ_READY_OUT    <= 1'b0;
			DATA_TAKE_OUT    <= 1'b0;
			DATA_RESTART_OUT <= 1'b0;
			RD_DATA_OUT      <= 8'h00;
			RD_VALID_OUT     <= 1'b0;
			RESP_VALID_OUT   <= 1'b0;
			RESP_OUT         <= '0;
		end else begin
			go               <= 1'b0;
			bbt_we           <= 1'b0;
			DATA_TAKE_OUT    <= 1'b0;
			DATA_RESTART_OUT <= 1'b0;
			RD_VALID_OUT     <= 1'b0;
			RESP_VALID_OUT   <= 1'b0;
			if (in_frame && !launched && !spi_busy) begin
				go            <= 1'b1;
				tx            <= tx_byte;
				launched      <= 1'b1;
				DATA_TAKE_OUT <= (state == S_LOAD) && load_data;
			end else if (in_frame && spi_done) begin
				launched <= 1'b0;
				idx      <= idx + 16'h0001;
				if (state == S_POLL && idx == POLL_STAT_IX)
					stat <= spi_rx;
				if (state == S_RDBUF && idx >= RDBUF_HDR && op == OP_READ) begin
					RD_DATA_OUT  <= spi_rx;
					RD_VALID_OUT <= 1'b1;
				end
				if (last) begin
					cs_n  <= 1'b1;
					pend  <= follow;
					state <= S_GAP;
					if (state == S_POLL && !rx_busy && op == OP_INIT) begin
						op   <= OP_SCAN;
						blk  <= '0;
						page <= '0;
						len  <= LEN_W'(1);
					end
					if (state == S_RDBUF && op == OP_SCAN) begin
						bbt_we <= 1'b1;
						bbt_wa <= blk;
						bbt_wd <= (spi_rx == BAD_MARK);
						blk    <= blk + 1'b1;
					end
				end
			end
			case (state)
				S_IDLE: begin
					if (REQ_VALID_IN) begin
						REQ_READY_OUT <= 1'b0;
						op            <= REQ_IN.op;
						blk           <= REQ_IN.blk;
						page          <= REQ_IN.page;
						len           <= REQ_IN.len;
						retry         <= '0;
						chk           <= 1'b0;
						state         <= S_CHECK;
						if (REQ_IN.op == OP_READ) begin
							pend  <= S_RD13;
							state <= S_GAP;
						end else if (REQ_IN.op == OP_INIT || REQ_IN.op == OP_SCAN) begin
							op    <= OP_SCAN;
							blk   <= '0;
							page  <= '0;
							len   <= LEN_W'(1);
							pend  <= S_RD13;
							state <= S_GAP;
						end
					end
				end
				S_GAP: begin
					gap <= gap + 1'b1;
					if (gap == GAP_LAST) begin
						gap           <= '0;
						state         <= pend;
						idx           <= 16'h0000;
						cs_n          <= !is_frame(pend);
						REQ_READY_OUT <= (pend == S_IDLE);
					end
				end
				S_CHECK: begin
					chk <= !chk;
					if (chk && !bbt_bad) begin
						pend  <= S_WREN;
						state <= S_GAP;
					end else if (chk && relocating && retry != RETRY_MAX) begin
						blk   <= alloc;
						alloc <= alloc + 1'b1;
						retry <= retry + 1'b1;
					end else if (chk) begin
						RESP_OUT.status  <= relocating ? RS_PROG_FAIL : RS_REFUSED;
						RESP_OUT.blk     <= blk;
						RESP_OUT.ecc     <= 2'h0;
						RESP_OUT.rewrite <= 1'b0;
						state            <= S_RESP;
					end
				end
				S_DONE: begin
					state            <= S_RESP;
					RESP_OUT.blk     <= blk;
					RESP_OUT.ecc     <= ecc;
					RESP_OUT.rewrite <= (op == OP_READ) && (ecc == ECC_NEAR);
					RESP_OUT.status  <= relocating ? RS_RELOCATED : RS_OK;
					if (op == OP_READ && ecc == ECC_UNCORR)
						RESP_OUT.status <= RS_ECC_UNCORR;
					if (done_fail) begin
						bbt_we <= 1'b1;
						bbt_wa <= blk;
						bbt_wd <= 1'b1;
						if (op == OP_ERASE)
							RESP_OUT.status <= RS_ERASE_FAIL;
						else if (op == OP_PROT)
							RESP_OUT.status <= RS_PROT_FAIL;
						else if (retry == RETRY_MAX)
							RESP_OUT.status <= RS_PROG_FAIL;
						else begin
							blk              <= alloc;
							alloc            <= alloc + 1'b1;
							retry            <= retry + 1'b1;
							chk              <= 1'b0;
							DATA_RESTART_OUT <= 1'b1;
							state            <= S_CHECK;
						end
					end
				end
				S_RESP: begin
					RESP_VALID_OUT <= 1'b1;
					REQ_READY_OUT  <= 1'b1;
					state          <= S_IDLE;
				end
				default: begin
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Bad-block table and serial engine
	// ---------------------------------------------------------------
	fbb_bbt_mem #(
		.AW (BLK_W),
		.W  (1)
	) u_bbt (
		.clk_in    (CLK_IN),
		.we_in     (bbt_we),
		.waddr_in  (bbt_wa),
		.wdata_in  (bbt_wd),
		.raddr_in  (blk),
		.rdata_out (bbt_bad)
	);

	fbb_spi #(
		.DIV (SPI_DIV)
	) u_spi (
		.clk_in   (CLK_IN),
		.nrst_in  (NRST_IN),
		.go_in    (go),
		.tx_in    (tx),
		.miso_in  (MISO_IN),
		.sck_out  (spi_sck),
		.mosi_out (spi_mosi),
		.busy_out (spi_busy),
		.done_out (spi_done),
		.rx_out   (spi_rx)
	);
endmodule : fbb_ctrl

// file: fbb_ctrl_assertions.sv
`timescale 1ns/10ps
module fbb_ctrl_chk (
	input wire logic               CLK_IN,
	input wire logic               NRST_IN,
	input wire logic               REQ_VALID_IN,
	input wire logic               REQ_READY_OUT,
	input wire logic               DATA_RESTART_OUT,
	input wire logic               RD_VALID_OUT,
	input wire logic               RESP_VALID_OUT,
	input wire fbb_pkg::fbb_resp_s RESP_OUT,
	input wire fbb_pkg::fbb_spi_s  SPI_OUT
);
	import fbb_pkg::*;
	int   gap;
	logic cs_seen;
	// ---------------------------------------------------------------
	// Chip-select high time and traffic since the last take
	// ---------------------------------------------------------------
	always_ff @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			gap     <= 0;
			cs_seen <= 1'b0;
		end else begin
			gap     <= SPI_OUT.cs_n ? gap + 1 : 0;
			cs_seen <= (REQ_VALID_IN && REQ_READY_OUT) ? 1'b0 : (cs_seen || !SPI_OUT.cs_n);
		end
	end
	// ---------------------------------------------------------------
	// Properties
	// ---------------------------------------------------------------
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (!NRST_IN);
	sequence s_take;
		REQ_VALID_IN && REQ_READY_OUT;
	endsequence
	sequence s_refuse;
		RESP_VALID_OUT && RESP_OUT.status == RS_REFUSED;
	endsequence
	a_take_drops_ready: assert property (s_take |=> !REQ_READY_OUT)
		else $error("ready stayed high after a take");
	a_refuse_no_early: assert property (s_take |=> !RESP_VALID_OUT [*3])
		else $error("response too soon after take");
	a_refuse_quiet: assert property (s_refuse |-> !cs_seen && SPI_OUT.cs_n)
		else $error("serial traffic on a refused request");
	a_cs_gap: assert property ($fell(SPI_OUT.cs_n) |-> gap >= CS_GAP_CYC)
		else $error("chip select high time too short");
	a_idle_quiet: assert property (REQ_READY_OUT |-> SPI_OUT.cs_n && !SPI_OUT.sck)
		else $error("serial activity while idle");
	a_resp_pulse: assert property (RESP_VALID_OUT |-> REQ_READY_OUT ##1 !RESP_VALID_OUT)
		else $error("response valid not a single pulse with ready");
	a_resp_hold: assert property (REQ_READY_OUT |-> $stable(RESP_OUT))
		else $error("response changed while idle");
	a_rd_in_op: assert property (RD_VALID_OUT |-> !REQ_READY_OUT)
		else $error("read byte outside an operation");
	a_restart_op: assert property (DATA_RESTART_OUT |-> !REQ_READY_OUT ##1 !DATA_RESTART_OUT)
		else $error("restart pulse outside a program");
endmodule : fbb_ctrl_chk

bind fbb_ctrl fbb_ctrl_chk chk_u (
	.CLK_IN(CLK_IN), .NRST_IN(NRST_IN), .REQ_VALID_IN(REQ_VALID_IN),
	.REQ_READY_OUT(REQ_READY_OUT), .DATA_RESTART_OUT(DATA_RESTART_OUT),
	.RD_VALID_OUT(RD_VALID_OUT), .RESP_VALID_OUT(RESP_VALID_OUT),
	.RESP_OUT(RESP_OUT), .SPI_OUT(SPI_OUT)
);

// file: fbb_dev_model.sv
`timescale 1ns/10ps
module fbb_dev_model (
	input  wire logic        sck_in,
	input  wire logic        cs_n_in,
	input  wire logic        mosi_in,
	input  wire logic [10:0] bad_in,
	input  wire logic [10:0] efail_in,
	input  wire logic [10:0] pfail_in,
	input  wire logic [1:0]  ecc_in,
	input  wire logic [2:0]  busy_in,
	output logic             miso_out,
	output int               viol_out
);
	import fbb_pkg::*;
	logic [7:0] q[$];
	logic [7:0] mem[int];
	logic [7:0] pbuf[int];
	bit         ret[int];
	logic [7:0] sh, ob;
	logic [1:0] ecc = 2'h0;
	logic       ef = 1'b0, pf = 1'b0;
	int         nb = 0, busy = 0, rrow = 0;
	initial miso_out = 1'b0;
	initial viol_out = 0;
	function automatic logic [7:0] out_byte(int i);
		int key;
		key = rrow * 4096 + i - 4;
		if (q.size() == 0) return 8'hA5;
		if (q[0] == CMD_GET_FEAT && i >= 2) return {2'b00, ecc, pf, ef, 1'b0, busy != 0};
		if (q[0] != CMD_READ_BUF || i < 4) return 8'hA5;
		if ((rrow >> PG_W) == bad_in) return BAD_MARK;
		return mem.exists(key) ? mem[key] : PAD_BYTE;
	endfunction : out_byte
	task automatic run();
		logic [7:0] c;
		int         row, blk;
		c   = q[0];
		row = (q.size() >= 4) ? {q[1], q[2], q[3]} : 0;
		blk = row >> PG_W;
		if (busy != 0 && c != CMD_GET_FEAT && c != CMD_RESET) viol_out++;
		if (c == CMD_GET_FEAT && busy != 0) busy--;
		if (c inside {CMD_ERASE, CMD_EXEC, CMD_PROT_EXEC, CMD_READ_ARRAY, CMD_RESET}) begin
			busy = busy_in;
			ef   = 1'b0;
			pf   = 1'b0;
			ecc  = (c == CMD_READ_ARRAY) ? ecc_in : 2'h0;
		end
		if (c inside {CMD_ERASE, CMD_EXEC, CMD_PROT_EXEC}) begin
			if (ret.exists(blk) || blk == bad_in) viol_out++;
			if (blk == bad_in) begin
				ef = (c == CMD_ERASE);
				pf = (c != CMD_ERASE);
			end else if (c == CMD_ERASE && blk == efail_in) begin
				ef       = 1'b1;
				ret[blk] = 1'b1;
			end else if (c != CMD_ERASE && blk == pfail_in) begin
				pf       = 1'b1;
				ret[blk] = 1'b1;
			end else if (c == CMD_EXEC) begin
				foreach (pbuf[k]) mem[row * 4096 + k] = pbuf[k];
			end
		end
		if (c == CMD_READ_ARRAY) rrow = row;
		if (c == CMD_LOAD) begin
			pbuf.delete();
			for (int i = 3; i < q.size(); i++) pbuf[i - 3] = q[i];
		end
	endtask : run
	// ---------------------------------------------------------------
	// Serial framing, mode 0
	// ---------------------------------------------------------------
	always @(negedge cs_n_in) begin
		q.delete();
		nb       = 0;
		ob       = out_byte(0);
		miso_out = ob[7];
	end
	always @(posedge sck_in) begin
		sh = {sh[6:0], mosi_in};
		nb++;
		if (nb % 8 == 0) q.push_back(sh);
	end
	always @(negedge sck_in) begin
		if (nb % 8 == 0) ob = out_byte(nb / 8);
		miso_out = ob[7 - nb % 8];
	end
	// Released line shows the inverse of its last value
	always @(posedge cs_n_in) begin
		miso_out = ~miso_out;
		if (q.size() > 0) run();
	end
endmodule : fbb_dev_model

// file: tb_top.sv
`timescale 1ns/10ps
module tb_top;
	import fbb_pkg::*;
	localparam int PB = 8;
	logic       clk = 1'b0, nrst = 1'b0, req_valid = 1'b0, miso;
	logic       ready, take, restart, rd_valid, resp_valid;
	logic [7:0] data_in = 8'h00, rd_data;
	logic [10:0] efail = 11'h7FF, pfail = 11'h7FF;
	logic [1:0] ecc = 2'h0;
	logic [2:0] busy_p = 3'h1;
	fbb_req_s   req = '0;
	fbb_resp_s  resp;
	fbb_spi_s   spi;
	logic [7:0] dbuf[PB];
	logic [7:0] rdq[$];
	bit         bt[int];
	fbb_op_e    wops[3] = '{OP_PROG, OP_ERASE, OP_PROT};
	int         err_total = 0, compares = 0, cyc = 0, didx = 0, ap = 0, rsts = 0;
	int         g, e, p, w, len, viol, pg;
	always #2.5 clk = ~clk;
	fbb_ctrl #(.PAGE_BYTES(PB), .SPI_DIV(3)) dut_u (
		.CLK_IN(clk), .NRST_IN(nrst), .REQ_VALID_IN(req_valid), .REQ_IN(req),
		.REQ_READY_OUT(ready), .DATA_IN(data_in), .DATA_TAKE_OUT(take),
		.DATA_RESTART_OUT(restart), .RD_DATA_OUT(rd_data), .RD_VALID_OUT(rd_valid),
		.RESP_VALID_OUT(resp_valid), .RESP_OUT(resp), .SPI_OUT(spi), .MISO_IN(miso)
	);
	fbb_dev_model dev_u (
		.sck_in(spi.sck), .cs_n_in(spi.cs_n), .mosi_in(spi.mosi), .bad_in(11'h000),
		.efail_in(efail), .pfail_in(pfail), .ecc_in(ecc), .busy_in(busy_p),
		.miso_out(miso), .viol_out(viol)
	);
	// ---------------------------------------------------------------
	// User buffer, read capture, watchdog
	// ---------------------------------------------------------------
	always @(posedge clk) begin
		if (rd_valid) rdq.push_back(rd_data);
		#1;
		if (restart) rsts++;
		if (restart || resp_valid) didx = 0;
		else if (take) didx++;
		data_in = dbuf[didx % PB];
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 90000) begin
			err_total++;
			tally_and_finish();
		end
	end
	task automatic tally_and_finish();
		if (err_total == 0 && compares > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// Bench model of the relocation pointer
	function automatic int alloc();
		while (bt.exists(ap)) ap++;
		ap++;
		return ap - 1;
	endfunction : alloc
	task automatic run_op(input fbb_op_e op, input int blk, input int n, input fbb_rs_e es,
		input int eb);
		@(posedge clk);
		#1;
		while (ready !== 1'b1) begin
			@(posedge clk);
			#1;
		end
		busy_p    = 3'($urandom % 4);
		req_valid = 1'b1;
		req       = '{op: op, blk: blk[BLK_W-1:0], page: pg[5:0], len: n[11:0]};
		@(posedge clk);
		#1 req_valid = 1'b0;
		while (resp_valid !== 1'b1) begin
			@(posedge clk);
			#1;
		end
		chk(resp.status, es);
		if (eb >= 0) chk(resp.blk, eb);
	endtask : run_op
	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	initial begin
		void'($urandom(32'hfb0e9957));
		foreach (dbuf[i]) dbuf[i] = $urandom;
		repeat (2) @(posedge clk);
		#1 nrst = 1'b1;
		bt[0] = 1'b1;
		g = 2 + $urandom % 11;
		e = g + 1;
		p = g + 2;
		w = g + 3;
		pg = $urandom % 64;
		foreach (wops[i]) run_op(wops[i], 0, PB, RS_REFUSED, -1);
		efail = e;
		run_op(OP_ERASE, e, 0, RS_ERASE_FAIL, e);
		bt[e] = 1'b1;
		run_op(OP_PROG, e, PB, RS_REFUSED, -1);
		len = 1 + $urandom % (PB - 1);
		run_op(OP_PROG, g, len, RS_OK, g);
		for (int k = 0; k < PB; k++) chk(dev_u.pbuf[k], k < len ? dbuf[k] : PAD_BYTE);
		for (int v = 0; v < 4; v++) begin
			ecc = v;
			rdq.delete();
			run_op(OP_READ, g, len, v == 2 ? RS_ECC_UNCORR : RS_OK, g);
			chk(rdq.size(), len);
			foreach (rdq[k]) chk(rdq[k], dbuf[k]);
			chk(resp.ecc, v);
			chk(resp.rewrite, v == 3);
		end
		ecc = 2'h0;
		run_op(OP_ERASE, g, 0, RS_OK, g);
		pfail = w;
		run_op(OP_PROG, w, PB, RS_RELOCATED, alloc());
		chk(rsts, 1);
		bt[w] = 1'b1;
		run_op(OP_PROG, w, PB, RS_REFUSED, -1);
		rdq.delete();
		run_op(OP_READ, 1, PB, RS_OK, 1);
		foreach (dbuf[k]) chk(rdq[k], dbuf[k]);
		pfail = p;
		run_op(OP_PROT, p, 0, RS_PROT_FAIL, p);
		run_op(OP_PROT, p, 0, RS_REFUSED, -1);
		run_op(OP_PROT, g, 0, RS_OK, g);
		@(posedge clk);
		#1 req = '{op: OP_SCAN, blk: '0, page: '0, len: '0};
		req_valid = 1'b1;
		@(posedge clk);
		#1 req_valid = 1'b0;
		run_op(OP_ERASE, 0, 0, RS_REFUSED, -1);
		chk(viol, 0);
		tally_and_finish();
	end
endmodule : tb_top
